// file: ssmc_pkg.sv
package ssmc_pkg;
  localparam int CLK_HZ = 40_000_000;
  localparam int FSW_MIN_KHZ = 300;
  localparam int FSW_MAX_KHZ = 2000;
  // Longest period rounds down, shortest rounds up
  localparam int PER_MAX_CYC = CLK_HZ / (FSW_MIN_KHZ * 1000);
  localparam int PER_MIN_CYC = (CLK_HZ + FSW_MAX_KHZ * 1000 - 1) / (FSW_MAX_KHZ * 1000);
  localparam logic [7:0] PER_MAX = 8'(PER_MAX_CYC);
  localparam logic [7:0] PER_MIN = 8'(PER_MIN_CYC);
  localparam int A_EXT_BIT = 5;
  localparam int B_EXT_BIT = 6;
  localparam int A_INT_BIT = 8;
  localparam int B_INT_BIT = 9;
  localparam int A_PLL_BIT = 14;
  localparam int B_PLL_BIT = 15;
  localparam int A_PH_LSB = 20;
  localparam int B_PH_LSB = 28;
  localparam int PHASE_STEP_DEG = 30;
  localparam logic [11:0] PHASE_STEPS = 12'(360 / PHASE_STEP_DEG);
  localparam logic [3:0] PHASE_CODE_MAX = 4'hB;
  localparam logic [31:0] CFG_RESET = 32'h0000_0000;

  typedef enum logic [1:0] {
    SSMC_MODE_OFF,
    SSMC_MODE_CLOSED,
    SSMC_MODE_PLL,
    SSMC_MODE_RSVD
  } ssmc_mode_t;

  function automatic ssmc_mode_t ssmc_decode(input logic ext, input logic int_en,
                                             input logic pll);
    ssmc_mode_t m;
    if (!int_en && !pll) begin
      m = SSMC_MODE_OFF;
    end else if (int_en && !ext && !pll) begin
      m = SSMC_MODE_CLOSED;
    end else if (!int_en && ext && pll) begin
      m = SSMC_MODE_PLL;
    end else begin
      m = SSMC_MODE_RSVD;
    end
    return m;
  endfunction
endpackage

// file: ssmc_chan.sv
`timescale 1ns/1ps
module ssmc_chan (
  input wire logic i_clk,                         // System clock
  input wire logic i_sys_rst,                     // Async reset, high
  input wire ssmc_pkg::ssmc_mode_t i_mode,        // Decoded sync mode
  input wire logic [3:0] i_phase_code,            // Phase offset code
  input wire logic [7:0] i_period,                // Free-running period, cycles
  input wire logic i_sync_rise,                   // Synchronised sync edge pulse
  output logic o_sw_clk,                          // Phase-shifted switching pulse
  output logic o_ref_clk,                         // 50 percent reference clock
  output logic o_locked                           // Following external clock
);
  typedef struct packed {
    logic [7:0] cnt;
    logic [8:0] since;
    logic locked;
    logic ref_clk;
    logic pulse;
  } ssmc_chan_t;

  ssmc_chan_t r_reg, r_next;
  logic [7:0] per;
  logic [7:0] off;
  logic [11:0] prod;
  logic run;

  always_comb begin
    per = i_period;
    if (i_period < ssmc_pkg::PER_MIN) begin
      per = ssmc_pkg::PER_MIN;
    end else if (i_period > ssmc_pkg::PER_MAX) begin
      per = ssmc_pkg::PER_MAX;
    end
    // Offset of code times one twelfth of the period
    prod = 12'(i_phase_code) * 12'(per);
    off = 8'(prod / ssmc_pkg::PHASE_STEPS);
    // Reserved codes fall back to no offset
    if (i_phase_code > ssmc_pkg::PHASE_CODE_MAX) begin
      off = 8'h00;
    end
    run = (i_mode == ssmc_pkg::SSMC_MODE_CLOSED) || (i_mode == ssmc_pkg::SSMC_MODE_PLL);
    r_next = r_reg;
    if (!run) begin
      r_next = '0;
    end else begin
      r_next.cnt = (r_reg.cnt >= per - 8'h01) ? 8'h00 : r_reg.cnt + 8'h01;
      r_next.since = (r_reg.since == 9'h1FF) ? r_reg.since : r_reg.since + 9'h001;
      // Loss of the external clock drops back to free running
      if (r_reg.since > {per, 1'b0}) begin
        r_next.locked = 1'b0;
      end
      if (i_mode == ssmc_pkg::SSMC_MODE_PLL && i_sync_rise) begin
        r_next.cnt = 8'h00;
        r_next.since = 9'h000;
        r_next.locked = 1'b1;
      end
      if (i_mode != ssmc_pkg::SSMC_MODE_PLL) begin
        r_next.locked = 1'b0;
      end
      // High for half the period, 50 percent nominal
      r_next.ref_clk = r_next.cnt < {1'b0, per[7:1]};
      r_next.pulse = r_next.cnt == off;
    end
  end

  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      r_reg <= '0;
    end else begin
      r_reg <= r_next;
    end
  end

  assign o_sw_clk = r_reg.pulse;
  assign o_ref_clk = r_reg.ref_clk;
  assign o_locked = r_reg.locked;

  a_phase_pos: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    r_reg.pulse && $stable(i_period) && $stable(i_phase_code) |-> r_reg.cnt == off)
    else $error("switching pulse off its phase slot");
endmodule

// file: ssmc_top.sv
`timescale 1ns/1ps
module ssmc_top (
  input wire logic i_clk,                         // System clock, 40 MHz
  input wire logic i_sys_rst,                     // Async reset, high
  input wire logic [31:0] i_cfg_wdata,            // Configuration word to write
  input wire logic i_cfg_we,                      // Write strobe, one cycle
  output logic [31:0] o_cfg_rdata,                // Configuration word readback
  input wire logic [7:0] i_period_a,              // Channel A period in cycles
  input wire logic [7:0] i_period_b,              // Channel B period in cycles
  input wire logic i_sync_i,                      // Sync pin level in
  output logic o_sync_o,                          // Sync pin level out
  output logic o_sync_oe,                         // Sync pin drive enable
  output logic o_sw_clk_a,                        // Channel A switching pulse
  output logic o_sw_clk_b,                        // Channel B switching pulse
  output ssmc_pkg::ssmc_mode_t o_mode_a,          // Channel A decoded mode
  output ssmc_pkg::ssmc_mode_t o_mode_b,          // Channel B decoded mode
  output logic o_locked_a,                        // Channel A following sync
  output logic o_locked_b,                        // Channel B following sync
  output logic o_cfg_reserved                     // Reserved setting in use
);
  typedef struct packed {
    logic [31:0] cfg;
    logic meta;
    logic sync_s;
    logic sync_d;
    logic sync_out;
    logic sync_oe;
  } ssmc_top_t;

  ssmc_top_t r_reg, r_next;
  ssmc_pkg::ssmc_mode_t mode [2];
  logic [3:0] code [2];
  logic [7:0] period [2];
  logic [1:0] sw_clk;
  logic [1:0] ref_clk;
  logic [1:0] locked;
  logic sync_rise;
  logic drive;

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    mode[0] = ssmc_pkg::ssmc_decode(r_reg.cfg[ssmc_pkg::A_EXT_BIT],
      r_reg.cfg[ssmc_pkg::A_INT_BIT], r_reg.cfg[ssmc_pkg::A_PLL_BIT]);
    mode[1] = ssmc_pkg::ssmc_decode(r_reg.cfg[ssmc_pkg::B_EXT_BIT],
      r_reg.cfg[ssmc_pkg::B_INT_BIT], r_reg.cfg[ssmc_pkg::B_PLL_BIT]);
    code[0] = r_reg.cfg[ssmc_pkg::A_PH_LSB +: 4];
    code[1] = r_reg.cfg[ssmc_pkg::B_PH_LSB +: 4];
    period[0] = i_period_a;
    period[1] = i_period_b;
  end

  // The second and third stages feed the edge detector, the first does not
  assign sync_rise = r_reg.sync_s && !r_reg.sync_d;

  // The pin is one wire: drive it only when nobody here listens to it
  assign drive = (mode[0] == ssmc_pkg::SSMC_MODE_CLOSED
    || mode[1] == ssmc_pkg::SSMC_MODE_CLOSED)
    && mode[0] != ssmc_pkg::SSMC_MODE_PLL && mode[1] != ssmc_pkg::SSMC_MODE_PLL;

  always_comb begin
    r_next = r_reg;
    if (i_cfg_we) begin
      r_next.cfg = i_cfg_wdata;
    end
    r_next.meta = i_sync_i;
    r_next.sync_s = r_reg.meta;
    r_next.sync_d = r_reg.sync_s;
    // Drive out the closed-loop reference clock
    r_next.sync_oe = drive;
    r_next.sync_out = 1'b0;
    if (drive) begin
      r_next.sync_out = (mode[0] == ssmc_pkg::SSMC_MODE_CLOSED) ? ref_clk[0] : ref_clk[1];
    end
  end

  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      r_reg <= '{cfg: ssmc_pkg::CFG_RESET, default: '0};
    end else begin
      r_reg <= r_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : g_chan
      ssmc_chan u_chan (
        .i_clk(i_clk),
        .i_sys_rst(i_sys_rst),
        .i_mode(mode[g]),
        .i_phase_code(code[g]),
        .i_period(period[g]),
        .i_sync_rise(sync_rise),
        .o_sw_clk(sw_clk[g]),
        .o_ref_clk(ref_clk[g]),
        .o_locked(locked[g])
      );
    end
  endgenerate

  assign o_cfg_rdata = r_reg.cfg;
  assign o_sync_o = r_reg.sync_out;
  assign o_sync_oe = r_reg.sync_oe;
  assign o_sw_clk_a = sw_clk[0];
  assign o_sw_clk_b = sw_clk[1];
  assign o_mode_a = mode[0];
  assign o_mode_b = mode[1];
  assign o_locked_a = locked[0];
  assign o_locked_b = locked[1];
  // Flag reserved mode and offset settings
  assign o_cfg_reserved = mode[0] == ssmc_pkg::SSMC_MODE_RSVD
    || mode[1] == ssmc_pkg::SSMC_MODE_RSVD
    || code[0] > ssmc_pkg::PHASE_CODE_MAX || code[1] > ssmc_pkg::PHASE_CODE_MAX;

  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_sys_rst);

  a_mode_a_off: assert property (
    i_cfg_we && !i_cfg_wdata[8] && !i_cfg_wdata[14] |=> o_mode_a == ssmc_pkg::SSMC_MODE_OFF)
    else $error("channel A not disabled");
  a_mode_a_pll: assert property (
    i_cfg_we && i_cfg_wdata[5] && !i_cfg_wdata[8] && i_cfg_wdata[14]
    |=> o_mode_a == ssmc_pkg::SSMC_MODE_PLL)
    else $error("channel A not in locked mode");
  a_mode_b_closed: assert property (
    i_cfg_we && !i_cfg_wdata[6] && i_cfg_wdata[9] && !i_cfg_wdata[15]
    |=> o_mode_b == ssmc_pkg::SSMC_MODE_CLOSED)
    else $error("channel B not in closed-loop mode");
  a_phase_b_read: assert property (
    i_cfg_we |=> o_cfg_rdata[31:28] == $past(i_cfg_wdata[31:28]))
    else $error("channel B offset field not stored");
  a_rsvd_code: assert property (
    i_cfg_we && i_cfg_wdata[23:20] > 4'hB |=> o_cfg_reserved)
    else $error("reserved offset code not flagged");
  a_sync_high: assert property (
    $rose(o_sync_o) && o_sync_oe && $stable(i_period_a) && $stable(i_period_b)
    |-> (o_sync_o || !o_sync_oe)[*8])
    else $error("sync output high too short");
  a_sync_fall: assert property (
    $rose(o_sync_o) && o_sync_oe |-> ##[1:70] (!o_sync_o || !o_sync_oe))
    else $error("sync output high too long");

  c_pll_lock: cover property (o_locked_a);
  c_sync_drive: cover property (o_sync_oe && $rose(o_sync_o));
  c_reserved: cover property (o_cfg_reserved);
endmodule

// file: ssmc_sync_src.sv
`timescale 1ns/1ps
// External clock source on the far side of the sync pin
module ssmc_sync_src #(
  parameter int HALF_NS = 100
) (
  input wire logic i_en,                          // Run the clock
  output logic o_sync                             // Clock onto the sync pin
);
  // steady period, no drift
  // Stands still low between bursts so a lost clock is really lost
  initial begin
    o_sync = 1'b0;
    forever begin
      wait (i_en === 1'b1);
      #(HALF_NS) o_sync = 1'b1;
      #(HALF_NS) o_sync = 1'b0;
    end
  end
endmodule

// file: ssmc_top_tb.sv
`timescale 1ns/1ps
module ssmc_top_tb;
  localparam logic [7:0] PER = 8'h18;
  logic clk, rst, we, src_en, src_clk, pin, sync_o, sync_oe, sw_a, sw_b, lk_a, lk_b, rsvd;
  logic [31:0] wdata, rdata, w;
  ssmc_pkg::ssmc_mode_t md_a, md_b, xa, xb;
  int failures = 0;
  int n_tests = 0;
  int n, d, ea, cb;
  // Pin level: device drive wins only while it is enabled
  assign pin = sync_oe ? sync_o : src_clk;
  ssmc_top ssmc_top_i (.i_clk(clk), .i_sys_rst(rst), .i_cfg_wdata(wdata), .i_cfg_we(we),
    .o_cfg_rdata(rdata), .i_period_a(PER), .i_period_b(PER), .i_sync_i(pin),
    .o_sync_o(sync_o), .o_sync_oe(sync_oe), .o_sw_clk_a(sw_a), .o_sw_clk_b(sw_b),
    .o_mode_a(md_a), .o_mode_b(md_b), .o_locked_a(lk_a), .o_locked_b(lk_b),
    .o_cfg_reserved(rsvd));
  ssmc_sync_src ssmc_sync_src_i (.i_en(src_en), .o_sync(src_clk));
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  ////////////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      failures++;
      $display("CHECK FAILED at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask
  task automatic final_report();
    $display("Comparisons %0d, mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  task automatic cfg_write(input logic [31:0] v);
    @(posedge clk);
    we <= 1'b1;
    wdata <= v;
    @(posedge clk);
    we <= 1'b0;
    @(posedge clk);
    #1;
  endtask
  // Cycles until the chosen signal reads at level lvl; bounded
  task automatic wait_lvl(input int sel, input logic lvl, output int cnt);
    cnt = 0;
    while (cnt < 200 && (sel == 0 ? sw_a : sel == 1 ? sw_b : sync_o) !== lvl) begin
      @(posedge clk);
      #1;
      cnt++;
    end
    if (cnt >= 200) begin
      failures++;
      final_report();
    end
  endtask
  function automatic ssmc_pkg::ssmc_mode_t exp_mode(input logic [2:0] eip);
    case (eip)
      3'b000, 3'b100: return ssmc_pkg::SSMC_MODE_OFF;
      3'b010: return ssmc_pkg::SSMC_MODE_CLOSED;
      3'b101: return ssmc_pkg::SSMC_MODE_PLL;
      default: return ssmc_pkg::SSMC_MODE_RSVD;
    endcase
  endfunction
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    rst = 1'b1;
    we = 1'b0;
    wdata = 32'h0;
    src_en = 1'b0;
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    #1;
    check(rdata, 32'h0);
    check(32'(md_a), 32'(ssmc_pkg::SSMC_MODE_OFF));
    // Every {ext, int, pll} combination, channel B with int and pll swapped
    for (int k = 0; k < 8; k++) begin
      w = 32'h0;
      {w[5], w[8], w[14]} = 3'(k);
      {w[6], w[15], w[9]} = 3'(k);
      xa = exp_mode(3'(k));
      xb = exp_mode({w[6], w[9], w[15]});
      cfg_write(w);
      check(rdata, w);
      check(32'(md_a), 32'(xa));
      check(32'(md_b), 32'(xb));
      check(32'(rsvd), 32'(xa == ssmc_pkg::SSMC_MODE_RSVD || xb == ssmc_pkg::SSMC_MODE_RSVD));
    end
    $display("test mode decode done");
    // Both closed-loop, same period: B lags A by the offset difference
    for (int c = 0; c < 16; c++) begin
      ea = (c < 12) ? c : 0;
      cb = (c < 12) ? 11 - c : 0;
      cfg_write(32'h0000_0300 | (32'(c) << 20) | (32'(cb) << 28));
      check(32'(rsvd), 32'(c >= 12));
      wait_lvl(0, 1'b1, n);
      if (sw_b === 1'b1) begin
        d = 0;
      end else begin
        wait_lvl(1, 1'b1, d);
      end
      check(32'(d), 32'((2 * cb - 2 * ea + 24) % 24));
    end
    $display("test phase offsets done");
    check(32'(sync_oe), 32'h1);
    wait_lvl(2, 1'b0, n);
    wait_lvl(2, 1'b1, n);
    wait_lvl(2, 1'b0, n);
    check(32'(n), 32'(PER / 2));
    wait_lvl(2, 1'b1, n);
    check(32'(n), 32'(PER - PER / 2));
    $display("test sync duty done");
    // A locked to the pin with B closed-loop, then B locked with A off: edges only reach the locked channel
    cfg_write(32'h0000_4220);
    check(32'(sync_oe), 32'h0);
    @(posedge clk);
    src_en <= 1'b1;
    repeat (60) @(posedge clk);
    #1;
    check(32'(lk_a), 32'h1);
    check(32'(lk_b), 32'h0);
    @(posedge clk);
    src_en <= 1'b0;
    repeat (3 * PER + 10) @(posedge clk);
    #1;
    check(32'(lk_a), 32'h0);
    cfg_write(32'h0000_8040);
    @(posedge clk);
    src_en <= 1'b1;
    repeat (60) @(posedge clk);
    #1;
    check(32'(lk_b), 32'h1);
    check(32'(lk_a), 32'h0);
    @(posedge clk);
    src_en <= 1'b0;
    $display("test phase lock done");
    // Reset in mid-run clears the stored word
    @(posedge clk);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    #1;
    check(rdata, 32'h0);
    check(32'(md_b), 32'(ssmc_pkg::SSMC_MODE_OFF));
    check(32'(lk_b), 32'h0);
    $display("test second reset done");
    final_report();
  end
endmodule
